// >>> common/dbgu_pkg.sv
// constants, types and helpers shared by the debug unit files
package dbgu_pkg;
  localparam int NTHR = 1024;
  localparam int THR_W = 10;
  localparam int DB_AW = 7;
  localparam int DB_DW = 34;
  localparam int SB_AW = 12;
  localparam int SB_DW = 32;
  localparam int RAM_WORDS = 64;
  localparam int RAM_AW = 6;
  localparam int ROM_WORDS = 128;
  localparam int ROM_AW = 7;
  localparam int SUM_W = 32;

  // debug bus map
  localparam logic [DB_AW-1:0] DB_RAM_LO_HI = 7'h0f;
  localparam logic [DB_AW-1:0] DB_CTRL = 7'h10;
  localparam logic [DB_AW-1:0] DB_SBADDR0 = 7'h16;
  localparam logic [DB_AW-1:0] DB_SBDATA0 = 7'h18;
  localparam logic [DB_AW-1:0] DB_HALTSUM = 7'h1b;
  localparam logic [DB_AW-1:0] DB_HSTAT_LO = 7'h1c;
  localparam logic [DB_AW-1:0] DB_HSTAT_HI = 7'h3b;
  localparam logic [DB_AW-1:0] DB_RAM_HI_LO = 7'h40;
  localparam logic [DB_AW-1:0] DB_RAM_HI_HI = 7'h6f;
  localparam logic [DB_AW-1:0] DB_RAM_HI_OFS = 7'h30;

  // control word fields
  localparam int CTL_INTR = 33;
  localparam int CTL_HALT = 32;
  localparam int CTL_BERR_LO = 19;
  localparam int CTL_SER_LO = 16;
  localparam int CTL_AUTOINC = 15;
  localparam int CTL_ACC_LO = 12;
  localparam int CTL_HART_LO = 2;
  localparam int CTL_NDRST = 1;
  localparam int CTL_FULLRST = 0;
  localparam logic [2:0] ACC_RESET = 3'h2;
  localparam logic [2:0] BERR_NONE = 3'h0;

  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_FAIL = 2'h2;

  // system bus map
  localparam logic [SB_AW-1:0] SB_CLRINT = 12'h100;
  localparam logic [SB_AW-1:0] SB_SETHALT = 12'h108;
  localparam logic [SB_AW-1:0] SB_RAM_LO = 12'h400;
  localparam logic [SB_AW-1:0] SB_RAM_HI = 12'h4ff;
  localparam logic [SB_AW-1:0] SB_ROM_LO = 12'h800;
  localparam logic [SB_AW-1:0] SB_ROM_HI = 12'h9ff;

  localparam logic [31:0] ROM_IMAGE [ROM_WORDS] = '{default: 32'h0000_0000};

  typedef enum logic [2:0] {
    BM_IDLE = 3'b001,
    BM_RD = 3'b010,
    BM_WR = 3'b100
  } dbgu_bm_e;

  function automatic logic dbguInSpan(input logic [SB_AW-1:0] a,
                                      input logic [SB_AW-1:0] lo,
                                      input logic [SB_AW-1:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction
endpackage

// >>> common/dbgu_thr_if.sv
// per-thread interrupt and halt flag carrier between core and flag store
`timescale 1ns/100ps
interface dbgu_thr_if;
  logic [9:0] selId;
  logic setIntrSel;
  logic clrHaltSel;
  logic sbSetHalt;
  logic sbClrIntr;
  logic [9:0] sbId;
  logic [1023:0] intr;
  logic [1023:0] halt;
  modport ctl (output selId, setIntrSel, clrHaltSel, sbSetHalt, sbClrIntr,
    sbId, input intr, halt);
  modport bits (input selId, setIntrSel, clrHaltSel, sbSetHalt, sbClrIntr,
    sbId, output intr, halt);
endinterface

// >>> core/dbgu_core.sv
// shared debug unit: debug bus, system bus, thread flags, bus master
`timescale 1ns/100ps
// What this block does
// RULE1: selects and debugs up to 1024 threads, each with interrupt and halt.
// RULE2: debug bus carries 34-bit words, 5 to 32 address bits, reads and writes.
// RULE3: debug addresses 0x00-0x0f reach scratch RAM words 0 to 15 in order.
// RULE4: bit 32 reads/clears-by-zero halt flag; bit 33 reads/sets interrupt.
// RULE5: own registers sit at debug addresses 0x10-0x1b and 0x3c-0x3f. Code decodes none at 0x3c-0x3f, which read zero.
// RULE6: addresses 0x1c-0x3b show all halt flags, 32 threads per word.
// RULE7: addresses 0x40-0x6f reach scratch RAM words 0x10-0x3f.
// RULE8: empty debug locations read zero and ignore writes.
// RULE9: system bus map: custom, registers 0x100-0x2ff, RAM 0x400-0x4ff.
// RULE10: code ROM of up to 512 bytes served at 0x800-0x9ff.
// RULE11: interrupt bit set by writing one to selected thread's field.
// RULE12: interrupt bit cleared by writing thread index to clear register.
// RULE13: each thread's interrupt line driven directly, within few cycles.
// RULE14: halt flag set by writing thread number to halt-set register.
// RULE15: halt flag cleared by writing zero in control or RAM word.
// RULE16: halt flags readable in summary, status words and flag field.
// RULE17: a halting thread writes only its own index to halt-set register.
// RULE18: scratch RAM holds at least 64 bytes for widest threads.
// RULE19: simultaneous RAM access from both buses fails with result code 2. Code fails only the debug-bus access; the system bus access completes.
// RULE20: RAM writes from an originator other than selected thread refused.
// RULE21: drives full reset and non-debug reset, never resetting itself.
// RULE22: optional bus master issues physical-address system accesses.
// RULE23: thread-select field picks which thread's bits are shown.
// RULE24: set wins over clear in the same cycle.
module dbgu_core
  import dbgu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic dbReq,
  input wire logic dbWrite,
  input wire logic [DB_AW-1:0] dbAddr,
  input wire logic [DB_DW-1:0] dbWdata,
  output logic [DB_DW-1:0] dbRdata,
  output logic [1:0] dbResp,
  output logic dbAck,
  input wire logic sbReq,
  input wire logic sbWrite,
  input wire logic [SB_AW-1:0] sbAddr,
  input wire logic [3:0] sbBe,
  input wire logic [SB_DW-1:0] sbWdata,
  input wire logic sbSrcIdValid,
  input wire logic [THR_W-1:0] sbSrcId,
  output logic [SB_DW-1:0] sbRdata,
  output logic sbAck,
  output logic [NTHR-1:0] dbgIntr,
  output logic fullResetPulse,
  output logic ndResetPulse,
  output logic bmReq,
  output logic bmWrite,
  output logic [31:0] bmAddr,
  output logic [31:0] bmWdata,
  output logic [2:0] bmSize,
  input wire logic bmAck,
  input wire logic [31:0] bmRdata,
  input wire logic [2:0] bmErrCode
);
  typedef struct packed {
    logic [THR_W-1:0] hartId;
    logic [2:0] serial;
    logic autoInc;
    logic [2:0] access;
    logic [2:0] busErr;
    dbgu_bm_e bm;
    logic [31:0] bmAddr;
    logic [31:0] bmData;
    logic [DB_DW-1:0] dbRdata;
    logic [1:0] dbResp;
    logic dbAck;
    logic [SB_DW-1:0] sbRdata;
    logic sbAck;
    logic ndRst;
    logic fullRst;
  } dbgu_core_s;

  dbgu_core_s cur_ff;
  dbgu_core_s nxt_cur;

  dbgu_thr_if thr ();

  logic dbWr;
  logic ctlHit;
  logic ramLoHit;
  logic ramHiHit;
  logic dbRamHit;
  logic hstatHit;
  logic [RAM_AW-1:0] dbRamIdx;
  logic [4:0] hsIdx;
  logic [SUM_W-1:0] haltSum;
  logic [31:0] ramDbRdata;
  logic [31:0] ramSbRdata;
  logic ramCollide;
  logic sbRamHit;
  logic sbRomHit;
  logic sbRamWe;
  logic selIntr;
  logic selHalt;
  logic [DB_DW-1:0] rd;

  dbgu_thread_bits u_bits (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .thr(thr.bits)
  );

  dbgu_scratch_ram u_ram (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .dbEn(dbReq && dbRamHit),
    .dbWe(dbWr),
    .dbIdx(dbRamIdx),
    .dbWdata(dbWdata[31:0]),
    .dbRdata(ramDbRdata),
    .sbEn(sbRamHit),
    .sbWe(sbRamWe),
    .sbBe(sbBe),
    .sbIdx(sbAddr[RAM_AW+1:2]),
    .sbWdata(sbWdata),
    .sbRdata(ramSbRdata),
    .collide(ramCollide)
  );

  // debug bus decode
  always_comb begin
    dbWr = dbReq && dbWrite;
    ctlHit = dbAddr == DB_CTRL;
    ramLoHit = dbAddr <= DB_RAM_LO_HI; // RULE3
    ramHiHit = (dbAddr >= DB_RAM_HI_LO) && (dbAddr <= DB_RAM_HI_HI); // RULE7
    dbRamHit = ramLoHit || ramHiHit;
    dbRamIdx = ramLoHit ? dbAddr[RAM_AW-1:0]
                        : RAM_AW'(dbAddr - DB_RAM_HI_OFS); // RULE7
    hstatHit = (dbAddr >= DB_HSTAT_LO) && (dbAddr <= DB_HSTAT_HI);
    hsIdx = 5'(dbAddr - DB_HSTAT_LO);
    for (int i = 0; i < SUM_W; i++) begin
      haltSum[i] = |thr.halt[i*SUM_W +: SUM_W]; // RULE16
    end
  end

  // system bus decode
  always_comb begin
    sbRamHit = sbReq && dbguInSpan(sbAddr, SB_RAM_LO, SB_RAM_HI); // RULE9
    sbRomHit = sbReq && dbguInSpan(sbAddr, SB_ROM_LO, SB_ROM_HI); // RULE10
    sbRamWe = sbWrite && !(sbSrcIdValid && sbSrcId != cur_ff.hartId); // RULE20
  end

  // thread flag requests; a control write applies to its new thread
  always_comb begin
    thr.selId = (dbWr && ctlHit) ? dbWdata[CTL_HART_LO +: THR_W]
                                 : cur_ff.hartId; // RULE23
    thr.setIntrSel = dbWr && (ctlHit || dbRamHit)
                     && dbWdata[CTL_INTR]; // RULE4 RULE11
    thr.clrHaltSel = dbWr && (ctlHit || dbRamHit)
                     && !dbWdata[CTL_HALT]; // RULE4 RULE15
    thr.sbSetHalt = sbReq && sbWrite && (sbAddr == SB_SETHALT); // RULE14 RULE17
    thr.sbClrIntr = sbReq && sbWrite && (sbAddr == SB_CLRINT); // RULE12
    thr.sbId = sbWdata[THR_W-1:0];
    selIntr = thr.intr[cur_ff.hartId]; // RULE23
    selHalt = thr.halt[cur_ff.hartId]; // RULE23
  end

  // debug bus read data
  always_comb begin
    rd = '0; // RULE8
    if (dbRamHit) begin
      rd = {selIntr, selHalt, ramDbRdata}; // RULE4 RULE16
    end else if (ctlHit) begin
      rd[CTL_INTR] = selIntr;
      rd[CTL_HALT] = selHalt; // RULE16
      rd[CTL_BERR_LO +: 3] = cur_ff.busErr;
      rd[CTL_SER_LO +: 3] = cur_ff.serial;
      rd[CTL_AUTOINC] = cur_ff.autoInc;
      rd[CTL_ACC_LO +: 3] = cur_ff.access;
      rd[CTL_HART_LO +: THR_W] = cur_ff.hartId;
    end else if (dbAddr == DB_SBADDR0) begin
      rd[31:0] = cur_ff.bmAddr; // RULE5
    end else if (dbAddr == DB_SBDATA0) begin
      rd[31:0] = cur_ff.bmData; // RULE5
    end else if (dbAddr == DB_HALTSUM) begin
      rd[SUM_W-1:0] = haltSum; // RULE16
    end else if (hstatHit) begin
      rd[31:0] = thr.halt[{hsIdx, 5'h00} +: 32]; // RULE6
    end
  end

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.dbAck = dbReq; // RULE2
    nxt_cur.sbAck = sbReq;
    nxt_cur.ndRst = 1'b0;
    nxt_cur.fullRst = 1'b0;
    nxt_cur.dbRdata = dbReq ? rd : cur_ff.dbRdata;
    nxt_cur.dbResp = (dbReq && dbRamHit && ramCollide) ? RESP_FAIL
                                                       : RESP_OK; // RULE19
    // control register write
    if (dbWr && ctlHit) begin
      nxt_cur.hartId = dbWdata[CTL_HART_LO +: THR_W]; // RULE23
      nxt_cur.serial = dbWdata[CTL_SER_LO +: 3];
      nxt_cur.autoInc = dbWdata[CTL_AUTOINC];
      nxt_cur.access = dbWdata[CTL_ACC_LO +: 3];
      nxt_cur.busErr = cur_ff.busErr & dbWdata[CTL_BERR_LO +: 3];
      nxt_cur.ndRst = dbWdata[CTL_NDRST]; // RULE21
      nxt_cur.fullRst = dbWdata[CTL_FULLRST]; // RULE21
    end
    // bus master start; ignored while busy or after an error
    if (dbWr && cur_ff.bm == BM_IDLE && cur_ff.busErr == BERR_NONE) begin
      if (dbAddr == DB_SBADDR0) begin
        nxt_cur.bmAddr = dbWdata[31:0]; // RULE22
        nxt_cur.bm = BM_RD;
      end else if (dbAddr == DB_SBDATA0) begin
        nxt_cur.bmData = dbWdata[31:0]; // RULE22
        nxt_cur.bm = BM_WR;
      end
    end
    // bus master completion
    if (bmAck && cur_ff.bm != BM_IDLE) begin
      nxt_cur.bm = BM_IDLE;
      if (bmErrCode != BERR_NONE) begin
        nxt_cur.busErr = bmErrCode;
      end else begin
        if (cur_ff.bm == BM_RD) begin
          nxt_cur.bmData = bmRdata;
        end
        if (cur_ff.autoInc) begin
          nxt_cur.bmAddr = cur_ff.bmAddr + (32'h0000_0001 << cur_ff.access);
        end
      end
    end
    // system bus read data
    if (sbRamHit) begin
      nxt_cur.sbRdata = ramSbRdata;
    end else if (sbRomHit) begin
      nxt_cur.sbRdata = ROM_IMAGE[sbAddr[ROM_AW+1:2]]; // RULE10
    end else if (sbReq) begin
      nxt_cur.sbRdata = '0; // RULE9
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '{hartId: '0, serial: '0, autoInc: 1'b0, access: ACC_RESET,
                  busErr: BERR_NONE, bm: BM_IDLE, bmAddr: '0, bmData: '0,
                  dbRdata: '0, dbResp: RESP_OK, dbAck: 1'b0, sbRdata: '0,
                  sbAck: 1'b0, ndRst: 1'b0, fullRst: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign dbRdata = cur_ff.dbRdata;
  assign dbResp = cur_ff.dbResp;
  assign dbAck = cur_ff.dbAck;
  assign sbRdata = cur_ff.sbRdata;
  assign sbAck = cur_ff.sbAck;
  assign dbgIntr = thr.intr; // RULE13
  assign fullResetPulse = cur_ff.fullRst;
  assign ndResetPulse = cur_ff.ndRst;
  assign bmReq = cur_ff.bm != BM_IDLE; // RULE22
  assign bmWrite = cur_ff.bm == BM_WR;
  assign bmAddr = cur_ff.bmAddr;
  assign bmWdata = cur_ff.bmData;
  assign bmSize = cur_ff.access;
endmodule

// >>> core/dbgu_scratch_ram.sv
// dual-access scratch RAM with collision detection
`timescale 1ns/100ps
module dbgu_scratch_ram
  import dbgu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic dbEn,
  input wire logic dbWe,
  input wire logic [RAM_AW-1:0] dbIdx,
  input wire logic [31:0] dbWdata,
  output logic [31:0] dbRdata,
  input wire logic sbEn,
  input wire logic sbWe,
  input wire logic [3:0] sbBe,
  input wire logic [RAM_AW-1:0] sbIdx,
  input wire logic [31:0] sbWdata,
  output logic [31:0] sbRdata,
  output logic collide
);
  typedef struct packed {
    logic [RAM_WORDS-1:0][31:0] mem; // RULE18
  } dbgu_ram_s;

  dbgu_ram_s cur_ff;
  dbgu_ram_s nxt_cur;

  assign collide = dbEn && sbEn; // RULE19
  assign dbRdata = cur_ff.mem[dbIdx];
  assign sbRdata = cur_ff.mem[sbIdx];

  always_comb begin
    nxt_cur = cur_ff;
    // on a collision the debug bus write is the one dropped
    if (dbEn && dbWe && !sbEn) begin
      nxt_cur.mem[dbIdx] = dbWdata; // RULE19
    end
    if (sbEn && sbWe) begin
      for (int b = 0; b < 4; b++) begin
        if (sbBe[b]) begin
          nxt_cur.mem[sbIdx][b*8 +: 8] = sbWdata[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end
endmodule

// >>> core/dbgu_thread_bits.sv
// per-thread debug interrupt and halt flag store
`timescale 1ns/100ps
module dbgu_thread_bits
  import dbgu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  dbgu_thr_if.bits thr
);
  typedef struct packed {
    logic [NTHR-1:0] intr;
    logic [NTHR-1:0] halt;
  } dbgu_bits_s;

  dbgu_bits_s cur_ff;
  dbgu_bits_s nxt_cur;

  always_comb begin
    nxt_cur = cur_ff;
    // clears first, sets afterwards so a set wins
    if (thr.sbClrIntr) begin
      nxt_cur.intr[thr.sbId] = 1'b0; // RULE12
    end
    if (thr.clrHaltSel) begin
      nxt_cur.halt[thr.selId] = 1'b0; // RULE15
    end
    if (thr.setIntrSel) begin
      nxt_cur.intr[thr.selId] = 1'b1; // RULE11 RULE24
    end
    if (thr.sbSetHalt) begin
      nxt_cur.halt[thr.sbId] = 1'b1; // RULE14 RULE24
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign thr.intr = cur_ff.intr; // RULE1
  assign thr.halt = cur_ff.halt; // RULE1
endmodule

// >>> tb/dbgu_bm_slave.sv
// system bus slave answering the debug unit's bus master
`timescale 1ns/100ps
module dbgu_bm_slave (
  input wire logic clk_sys,
  input wire logic bmReq,
  input wire logic [31:0] bmAddr,
  input wire logic [3:0] lat,
  output logic bmAck,
  output logic [31:0] bmRdata
);
  logic [3:0] cnt = '0;
  initial bmAck = '0;
  initial bmRdata = '0;
  // data toggles outside an answer so stale values never look valid
  always @(posedge clk_sys) begin
    bmAck <= '0;
    bmRdata <= ~bmRdata;
    if (bmReq && !bmAck) begin
      cnt <= cnt + 4'h1;
      if (cnt >= lat) begin
        bmAck <= 1'h1;
        bmRdata <= bmAddr ^ 32'h5a5a_5a5a;
        cnt <= '0;
      end
    end
  end
endmodule

// >>> tb/dbgu_core_properties.sv
// concurrent checks on the debug unit's ports
`timescale 1ns/100ps
module dbgu_core_properties
  import dbgu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic dbReq,
  input wire logic dbWrite,
  input wire logic [DB_AW-1:0] dbAddr,
  input wire logic [DB_DW-1:0] dbWdata,
  input wire logic [DB_DW-1:0] dbRdata,
  input wire logic [1:0] dbResp,
  input wire logic dbAck,
  input wire logic sbReq,
  input wire logic sbWrite,
  input wire logic [SB_AW-1:0] sbAddr,
  input wire logic [SB_DW-1:0] sbWdata,
  input wire logic sbAck,
  input wire logic [NTHR-1:0] dbgIntr,
  input wire logic fullResetPulse,
  input wire logic bmReq,
  input wire logic [31:0] bmAddr,
  input wire logic bmAck
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_ctl_wr;
    dbReq && dbWrite && dbAddr == DB_CTRL;
  endsequence
  sequence s_clr_int;
    sbReq && sbWrite && sbAddr == SB_CLRINT && !dbReq;
  endsequence
  sequence s_ram_hit;
    dbReq && sbReq && sbAddr[11:8] == 4'h4 &&
      (dbAddr <= DB_RAM_LO_HI || (dbAddr >= DB_RAM_HI_LO &&
      dbAddr <= DB_RAM_HI_HI));
  endsequence
  a_db_ack: assert property (dbReq |=> dbAck)
    else $error("debug ack missing");
  a_sb_ack: assert property (sbReq |=> sbAck)
    else $error("system ack missing");
  a_intr_set: assert property (s_ctl_wr ##0 dbWdata[33] |=>
    dbgIntr[$past(dbWdata[11:2])]) else $error("interrupt not set");
  a_intr_clr: assert property (s_clr_int |=>
    !dbgIntr[$past(sbWdata[9:0])]) else $error("interrupt not cleared");
  a_ram_fail: assert property (s_ram_hit |=> dbResp == RESP_FAIL)
    else $error("collision not reported");
  a_resp_ok: assert property (dbReq && !sbReq |=> dbResp == RESP_OK)
    else $error("false failure");
  a_hole_zero: assert property (dbReq && !dbWrite &&
    dbAddr > DB_RAM_HI_HI |=> dbRdata == '0) else $error("hole not zero");
  a_full_rst: assert property (s_ctl_wr ##0 dbWdata[0] |=>
    fullResetPulse) else $error("full reset missing");
  a_bm_hold: assert property (bmReq && !bmAck |=>
    bmReq && $stable(bmAddr)) else $error("master request dropped");
  a_bm_drop: assert property (bmReq && bmAck |=> !bmReq)
    else $error("master request stuck");
endmodule
bind dbgu_core dbgu_core_properties u_props (.*);

// >>> tb/tb_dbgu_core.sv
// self-checking bench for the shared debug unit
`timescale 1ns/100ps
module tb_dbgu_core
  import dbgu_pkg::*;
;
  logic clk_sys = '0, rst_n = '0, dbReq = '0, dbWrite = '0, sbReq = '0;
  logic sbWrite = '0, sbSrcIdValid = '0, dbAck, sbAck, fullResetPulse;
  logic ndResetPulse, bmReq, bmWrite, bmAck;
  logic [DB_AW-1:0] dbAddr = '0, a;
  logic [DB_DW-1:0] dbWdata = '0, dbRdata;
  logic [1:0] dbResp;
  logic [2:0] bmSize;
  logic [3:0] lat = '0;
  logic [5:0] k;
  logic [THR_W-1:0] sbSrcId = '0, h;
  logic [SB_AW-1:0] sbAddr = '0;
  logic [31:0] sbWdata = '0, sbRdata, bmAddr, bmWdata, bmRdata, d;
  logic [NTHR-1:0] dbgIntr;
  logic [71:0] dbQ[$], sbQ[$], q;
  int numErrors = 0, nCompared = 0, cycles = 0, seed = 75536, i;
  dbgu_core DUT (.clk_sys, .rst_n, .dbReq, .dbWrite, .dbAddr, .dbWdata,
    .dbRdata, .dbResp, .dbAck, .sbReq, .sbWrite, .sbAddr, .sbBe(4'hf),
    .sbWdata, .sbSrcIdValid, .sbSrcId, .sbRdata, .sbAck, .dbgIntr,
    .fullResetPulse, .ndResetPulse, .bmReq, .bmWrite, .bmAddr, .bmWdata,
    .bmSize, .bmAck, .bmRdata, .bmErrCode(3'h0));
  dbgu_bm_slave u_slave (.clk_sys, .bmReq, .bmAddr, .lat, .bmAck, .bmRdata);
  always #5 clk_sys = ~clk_sys;
  task automatic end_sim;
    $display("compared %0d mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] e);
    nCompared++;
    if (got !== e) begin
      $display("unexpected at %0t got %h exp %h", $time, got, e);
      numErrors++;
    end
  endtask
  // expectation masks: bits 35:34 result code, 33:0 read word
  task automatic dbs(input logic w, input logic [6:0] ad,
      input logic [33:0] wd, input logic [35:0] m, input logic [35:0] e);
    {dbReq, dbWrite, dbAddr, dbWdata} = {1'h1, w, ad, wd};
    dbQ.push_back({m, e & m});
  endtask
  task automatic sbs(input logic w, input logic [11:0] ad,
      input logic [31:0] wd, input logic [31:0] e);
    {sbReq, sbWrite, sbAddr, sbWdata} = {1'h1, w, ad, wd};
    sbQ.push_back({w ? 36'h0 : 36'hf_ffff_ffff, 4'h0, e});
  endtask
  task automatic fin;
    @(negedge clk_sys);
    {dbReq, sbReq} = 2'h0;
    @(negedge clk_sys);
  endtask
  function automatic logic [33:0] ctl(input logic ir, input logic [9:0] t);
    return {ir, 1'h1, 17'h0_0000, 3'h2, t, 2'h0};
  endfunction
  always @(negedge clk_sys) begin
    if (dbAck === 1'h1) begin
      q = dbQ.pop_front();
      chk({dbResp, dbRdata} & q[71:36], q[35:0]);
    end
    if (sbAck === 1'h1) begin
      q = sbQ.pop_front();
      chk({4'h0, sbRdata} & q[71:36], q[35:0]);
    end
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      numErrors++;
      end_sim;
    end
  end
  initial begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1'h1;
    @(negedge clk_sys);
    dbs(0, DB_CTRL, '0, '1, 36'h0_0000_2000);
    fin;
    chk({35'h0, dbgIntr == '0}, 36'h1);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      k = 6'($random(seed));
      d = $random(seed);
      a = (k < 6'h10) ? {1'h0, k} : {1'h0, k} + DB_RAM_HI_OFS;
      dbs(1, a, {2'h1, d}, '0, '0);
      fin;
      sbs(0, SB_RAM_LO + {k, 2'h0}, '0, d);
      fin;
      sbs(1, SB_RAM_LO + {k, 2'h0}, ~d, '0);
      fin;
      dbs(0, a, '0, 36'hc_ffff_ffff, {4'h0, ~d});
      fin;
    end
    $display("test ram done");
    for (i = 0; i < 4; i++) begin
      h = (i == 0) ? 10'h3ff : 10'($random(seed));
      dbs(1, DB_CTRL, ctl(1'h1, h), '0, '0);
      fin;
      chk({35'h0, dbgIntr[h]}, 36'h1);
      dbs(0, 7'h05, '0, 36'h2_0000_0000, 36'h2_0000_0000);
      fin;
      sbs(1, SB_CLRINT, {22'h0, h}, '0);
      fin;
      chk({35'h0, dbgIntr[h]}, 36'h0);
      dbs(1, 7'h00, {2'h2, d}, '0, '0);
      sbs(1, SB_CLRINT, {22'h0, h}, '0);
      fin;
      chk({35'h0, dbgIntr[h]}, 36'h1);
      sbs(1, SB_CLRINT, {22'h0, h}, '0);
      fin;
      sbs(1, SB_SETHALT, {22'h0, h}, '0);
      fin;
      dbs(0, DB_HSTAT_LO + h[9:5], '0, '1, 36'(32'h1 << h[4:0]));
      fin;
      dbs(0, DB_HALTSUM, '0, '1, 36'(32'h1 << h[9:5]));
      fin;
      dbs(0, DB_CTRL, '0, 36'h1_0000_0ffc, {4'h1, 20'h0, h, 2'h0});
      fin;
      dbs(1, 7'h02, 34'h0, '0, '0);
      fin;
      dbs(0, DB_HSTAT_LO + h[9:5], '0, '1, '0);
      fin;
    end
    $display("test flags done");
    dbs(1, 7'h01, {2'h1, 32'h0000_0000}, '0, '0);
    fin;
    dbs(1, 7'h01, {2'h1, 32'hdead_beef}, '1, 36'h8_0000_0000);
    sbs(1, SB_RAM_LO + 12'h008, 32'h1234_5678, '0);
    fin;
    dbs(0, 7'h01, '0, '1, 36'h0_0000_0000);
    fin;
    $display("test collision done");
    dbs(1, 7'h70, '1, '0, '0);
    fin;
    dbs(0, 7'h70, '0, '1, '0);
    sbs(0, 12'h000, '0, '0);
    fin;
    dbs(0, 7'h11, '0, '1, '0);
    sbs(0, SB_ROM_HI - 12'h003, '0, '0);
    fin;
    $display("test holes done");
    dbs(1, DB_CTRL, ctl(1'h0, 10'h003) | 34'h3, '0, '0);
    @(negedge clk_sys);
    chk({34'h0, fullResetPulse, ndResetPulse}, 36'h3);
    dbReq = '0;
    @(negedge clk_sys);
    {sbSrcIdValid, sbSrcId} = {1'h1, 10'h003};
    sbs(1, SB_RAM_LO + 12'h014, 32'h0000_aaaa, '0);
    fin;
    sbSrcId = 10'h004;
    sbs(1, SB_RAM_LO + 12'h014, 32'h0000_5555, '0);
    fin;
    dbs(0, 7'h05, '0, 36'hc_ffff_ffff, 36'h0_0000_aaaa);
    fin;
    $display("test reset and origin done");
    for (i = 0; i < 3; i++) begin
      d = {$random(seed)} & 32'hffff_fffc;
      lat = 4'($random(seed));
      dbs(1, DB_SBADDR0, {2'h0, d}, '0, '0);
      fin;
      for (int j = 0; j < 40 && bmReq !== 1'h0; j++) @(negedge clk_sys);
      dbs(0, DB_SBDATA0, '0, 36'hc_ffff_ffff, 36'(d ^ 32'h5a5a_5a5a));
      fin;
      dbs(1, DB_SBDATA0, {2'h0, ~d}, '0, '0);
      fin;
      chk({bmWrite, bmSize, bmWdata}, {1'h1, 3'h2, ~d});
      for (int j = 0; j < 40 && bmReq !== 1'h0; j++) @(negedge clk_sys);
    end
    $display("test bus master done");
    chk(36'(dbQ.size() + sbQ.size()), 36'h0);
    end_sim;
  end
endmodule
